/* hw/mie_alu.sv */
// Combinational ALU for the execute block.
// Assumes operands are already read from the file and working registers.
`timescale 1ns/100ps
module mie_alu (
  // Operation and operands
  input  wire mie_pkg::mie_op_t              op,
  input  wire logic [mie_pkg::DATA_W-1:0]    a_val,
  input  wire logic [mie_pkg::DATA_W-1:0]    w_val,
  input  wire logic [mie_pkg::B_W-1:0]       bit_sel,
  // Result and flags
  output logic      [mie_pkg::DATA_W-1:0]    result,
  output logic                               carry,
  output logic                               digit_carry_flag,
  output logic                               zero,
  output logic                               upd_cdc,
  output logic                               upd_z,
  output logic                               bit_val
);
  import mie_pkg::*;
  logic [DATA_W:0] diff;
  logic [4:0]      ldiff;
  always_comb begin
    diff             = {1'b0, a_val} + {1'b0, ~w_val} + 9'h001;
    ldiff            = {1'b0, a_val[3:0]} + {1'b0, ~w_val[3:0]} + 5'h01;
    result           = a_val;
    upd_cdc          = 1'b0;
    upd_z            = 1'b0;
    bit_val          = a_val[bit_sel];
    unique case (op)
      MIE_OP_SUB: begin
        result  = diff[DATA_W-1:0];
        upd_cdc = 1'b1;
        upd_z   = 1'b1;
      end
      MIE_OP_XOR: begin
        result = a_val ^ w_val;
        upd_z  = 1'b1;
      end
      MIE_OP_SWAP:   result = {a_val[3:0], a_val[7:4]};
      MIE_OP_BITCLR: result = a_val & ~(8'h01 << bit_sel);
      MIE_OP_BITSET: result = a_val | (8'h01 << bit_sel);
      default:       result = a_val;
    endcase
    carry            = diff[DATA_W];
    digit_carry_flag = ldiff[4];
    zero             = (result == 8'h00);
  end
endmodule // mie_alu

/* hw/mie_exec.sv */
// Instruction decode and execute core: one instruction per four-phase cycle.
// Assumes instruction word is valid by phase 0 and file read data returns combinationally.
`timescale 1ns/100ps
module mie_exec (
  // Clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rstn,
  // Instruction fetch
  input  wire logic [mie_pkg::INSN_W-1:0]    insn,
  output logic                               fetch_stb,
  output logic      [mie_pkg::PC_W-1:0]      pc,
  // File register port
  input  wire logic [mie_pkg::DATA_W-1:0]    file_rdata,
  output logic      [mie_pkg::FADDR_W-1:0]   file_addr,
  output logic                               file_rd,
  output logic                               file_we,
  output logic      [mie_pkg::DATA_W-1:0]    file_wdata,
  // Core state
  output logic      [mie_pkg::DATA_W-1:0]    acc,
  output logic                               carry_flag,
  output logic                               digit_carry_flag,
  output logic                               zero_flag,
  output logic                               nop_cycle,
  output logic      [1:0]                    qphase
);
  import mie_pkg::*;

  typedef enum logic {MIE_EXEC, MIE_FLUSH} mie_state_t;

  logic [1:0]          q_q;
  mie_state_t          st_q;
  logic [INSN_W-1:0]   ir_q;
  logic [DATA_W-1:0]   opa_q;
  mie_op_t             op;
  logic                uses_file;
  logic                lit_src;
  logic [DATA_W-1:0]   alu_res;
  logic                alu_c;
  logic                alu_dc;
  logic                alu_z;
  logic                upd_cdc;
  logic                upd_z;
  logic                bit_val;
  logic                to_file;
  logic                taken;

  // Decode helper used only for execute, on the latched word ir_q
  function automatic mie_op_t decode(input logic [INSN_W-1:0] w);
    mie_op_t o;
    o = MIE_OP_NOP;
    unique case (w[13:12])
      GRP_BYTE: begin
        if (w[11:8] == OP_SUB_ACC_FROM_REG)      o = MIE_OP_SUB;
        else if (w[11:8] == OP_XOR_ACC_WITH_REG) o = MIE_OP_XOR;
        else if (w[11:8] == OP_NIBBLE_SWAP_REG) o = MIE_OP_SWAP;
      end
      GRP_BIT: begin
        unique case (w[11:10])
          OP_BCF:  o = MIE_OP_BITCLR;
          OP_BSF:  o = MIE_OP_BITSET;
          default: o = MIE_OP_SKIP;
        endcase
      end
      GRP_JUMP: o = MIE_OP_JUMP;
      GRP_LIT: begin
        // Bit 8 ignored for subtract literal
        if (w[11:9] == OP_SUBL)      o = MIE_OP_SUB;
        else if (w[11:8] == OP_XORL) o = MIE_OP_XOR;
      end
    endcase
    return o;
  endfunction

  always_comb begin
    op        = decode(ir_q);
    lit_src   = (ir_q[13:12] == GRP_LIT);
    uses_file = (ir_q[13:12] == GRP_BYTE) || (ir_q[13:12] == GRP_BIT);
    to_file   = (ir_q[13:12] == GRP_BIT) || ir_q[D_POS];
    taken     = (op == MIE_OP_JUMP) ||
                ((op == MIE_OP_SKIP) && (bit_val == ir_q[10]));
  end

  mie_alu u_alu (
    .op               (op),
    .a_val            (opa_q),
    .w_val            (acc),
    .bit_sel          (ir_q[B_LSB +: B_W]),
    .result           (alu_res),
    .carry            (alu_c),
    .digit_carry_flag (alu_dc),
    .zero             (alu_z),
    .upd_cdc          (upd_cdc),
    .upd_z            (upd_z),
    .bit_val          (bit_val)
  );

  // Phase counter, four periods per cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) q_q <= Q_RESET;
    else       q_q <= q_q + 2'h1;
  end
  assign qphase = q_q;

  // Instruction latch and cycle state
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ir_q      <= '0;
      st_q      <= MIE_EXEC;
      fetch_stb <= 1'b0;
      pc        <= PC_RESET;
      nop_cycle <= 1'b0;
    end else begin
      fetch_stb <= (q_q == 2'h2);
      if (q_q == 2'h3) begin
        if (st_q == MIE_EXEC && taken) begin
          st_q      <= MIE_FLUSH;
          nop_cycle <= 1'b1;
          ir_q      <= '0;
          pc        <= (op == MIE_OP_JUMP) ? {pc[12:11], ir_q[JLIT_W-1:0]}
                                           : pc + 13'h0001;
        end else begin
          st_q      <= MIE_EXEC;
          nop_cycle <= 1'b0;
          ir_q      <= insn;
          pc        <= pc + 13'h0001;
        end
      end
    end
  end

  // Operand read in phase 1, before any store
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      opa_q     <= '0;
      file_addr <= '0;
      file_rd   <= 1'b0;
    end else begin
      file_addr <= ir_q[F_LSB +: FADDR_W];
      file_rd   <= (q_q == 2'h0) && uses_file && (st_q == MIE_EXEC);
      if (q_q == 2'h1)
        opa_q <= lit_src ? ir_q[LIT_W-1:0] : file_rdata;
    end
  end

  // Store phase: write back and flags
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      acc              <= W_RESET;
      carry_flag       <= 1'b0;
      digit_carry_flag <= 1'b0;
      zero_flag        <= 1'b0;
      file_we          <= 1'b0;
      file_wdata       <= '0;
    end else begin
      file_we <= 1'b0;
      if (q_q == 2'h2 && st_q == MIE_EXEC &&
          op != MIE_OP_NOP && op != MIE_OP_SKIP && op != MIE_OP_JUMP) begin
        if (uses_file && to_file) begin
          file_we    <= 1'b1;
          file_wdata <= alu_res;
        end else begin
          acc <= alu_res;
        end
        if (upd_cdc) begin
          carry_flag       <= alu_c;
          digit_carry_flag <= alu_dc;
        end
        if (upd_z) zero_flag <= alu_z;
      end
    end
  end
endmodule // mie_exec

/* hw/mie_pkg.sv */
// Package for the instruction execute block: field layout, opcodes, timing.
// Assumes 14-bit instruction words and an 8-bit data path.
package mie_pkg;
  localparam int INSN_W      = 14;
  localparam int DATA_W      = 8;
  localparam int FADDR_W     = 7;
  localparam int LIT_W       = 8;
  localparam int JLIT_W      = 11;
  localparam int PC_W        = 13;
  // Field positions
  localparam int F_LSB       = 0;
  localparam int D_POS       = 7;
  localparam int B_LSB       = 7;
  localparam int B_W         = 3;
  // Oscillator periods per instruction cycle
  localparam int QPHASES     = 4;
  localparam logic [1:0] Q_RESET = 2'h0;
  localparam logic [DATA_W-1:0]  W_RESET  = 8'h00;
  localparam logic [PC_W-1:0]    PC_RESET = 13'h0000;
  // Group codes in bits 13:12
  localparam logic [1:0] GRP_BYTE = 2'h0;
  localparam logic [1:0] GRP_BIT  = 2'h1;
  localparam logic [1:0] GRP_JUMP = 2'h2;
  localparam logic [1:0] GRP_LIT  = 2'h3;
  // Byte group opcodes in bits 11:8
  localparam logic [3:0] OP_SUB_ACC_FROM_REG = 4'h2;
  localparam logic [3:0] OP_XOR_ACC_WITH_REG = 4'h6;
  localparam logic [3:0] OP_NIBBLE_SWAP_REG = 4'he;
  // Literal group opcodes in bits 11:8 (bit 8 is don't care for sub)
  localparam logic [2:0] OP_SUBL  = 3'h6;
  localparam logic [3:0] OP_XORL  = 4'ha;
  // Bit group opcodes in bits 11:10
  localparam logic [1:0] OP_BCF   = 2'h0;
  localparam logic [1:0] OP_BSF   = 2'h1;
  localparam logic [1:0] OP_BTFSC = 2'h2;
  localparam logic [1:0] OP_BTFSS = 2'h3;

  typedef enum logic [2:0] {
    MIE_OP_NOP, MIE_OP_SUB, MIE_OP_XOR, MIE_OP_SWAP, MIE_OP_BITCLR,
    MIE_OP_BITSET, MIE_OP_SKIP, MIE_OP_JUMP
  } mie_op_t;
endpackage

/* sim/mie_exec_properties.sv */
// Timing checks on the execute core ports.
// Assumes one clock domain and the reset rstn.
`timescale 1ns/100ps
module mie_exec_properties (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rstn,
  // Observed outputs
  input wire logic       fetch_stb,
  input wire logic [6:0] file_addr,
  input wire logic       file_rd,
  input wire logic       file_we,
  input wire logic [7:0] acc,
  input wire logic       carry_flag,
  input wire logic       digit_carry_flag,
  input wire logic       zero_flag,
  input wire logic       nop_cycle,
  input wire logic [1:0] qphase
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  ph_wrap_a: assert property (qphase == 2'h3 |=> qphase == 2'h0)
    else $error("phase did not wrap");
  ph_step_a: assert property (qphase == 2'h1 |=> qphase == 2'h2)
    else $error("phase did not step");
  fetch_ph_a: assert property (qphase == 2'h2 |=> fetch_stb && qphase == 2'h3)
    else $error("fetch strobe missing");
  rd_ph_a: assert property (file_rd |-> qphase == 2'h1)
    else $error("file read outside phase one");
  rmw_ord_a: assert property (file_we |-> $past(file_rd, 2) && file_addr == $past(file_addr, 2))
    else $error("write without earlier read");
  we_acc_a: assert property (file_we |-> $stable(acc))
    else $error("acc changed on file write");
  flag_ph_a: assert property ($changed({carry_flag, digit_carry_flag, zero_flag}) |-> qphase == 2'h3)
    else $error("flags changed off phase three");
  nop_len_a: assert property ($rose(nop_cycle) |-> nop_cycle [*4])
    else $error("no-op cycle too short");
  nop_wr_a: assert property (nop_cycle |-> !file_we)
    else $error("write during no-op cycle");
  cover property (file_we);
  cover property ($rose(nop_cycle));
  cover property ($rose(zero_flag));
endmodule // mie_exec_properties
bind mie_exec mie_exec_properties u_props (.clk_sys, .rstn, .fetch_stb, .file_addr, .file_rd,
  .file_we, .acc, .carry_flag, .digit_carry_flag, .zero_flag, .nop_cycle, .qphase);

/* sim/mie_rf_model.sv */
// Register file model at the far side of the execute core.
// Assumes combinational reads and writes on file_we at the clock edge.
`timescale 1ns/100ps
module mie_rf_model (
  // Clock
  input  wire logic                        clk_sys,
  // File port
  input  wire logic [mie_pkg::FADDR_W-1:0] file_addr,
  input  wire logic                        file_rd,
  input  wire logic                        file_we,
  input  wire logic [mie_pkg::DATA_W-1:0]  file_wdata,
  output logic      [mie_pkg::DATA_W-1:0]  file_rdata
);
  import mie_pkg::*;
  logic [DATA_W-1:0] mem [128];
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i) ^ 8'h3c;
  always @(posedge clk_sys) if (file_we) mem[file_addr] <= file_wdata;
  // Outside a read the data is inverted so a stale sample shows up
  assign file_rdata = file_rd ? mem[file_addr] : ~mem[file_addr];
endmodule // mie_rf_model

/* sim/tb.sv */
// Self-checking bench for the execute core and a register file model.
// Assumes one word is taken at each phase three edge.
`timescale 1ns/100ps
module tb;
  import mie_pkg::*;
  logic              clk_sys = 1'b0;
  logic              rstn = 1'b0;
  logic [INSN_W-1:0] insn = '0;
  logic [7:0]        file_rdata, file_wdata, acc, w_x;
  logic [6:0]        file_addr;
  logic [PC_W-1:0]   pc;
  logic [1:0]        qphase;
  logic              fetch_stb, file_rd, file_we, nop_cycle, nop_seen;
  logic              carry_flag, digit_carry_flag, zero_flag;
  logic [2:0]        fl_x;
  logic [7:0]        fm [128];
  int                fails = 0;
  int                total_checks = 0;
  int                cyc = 0;
  always #2 clk_sys = ~clk_sys;
  mie_exec dut (.clk_sys, .rstn, .insn, .fetch_stb, .pc, .file_rdata, .file_addr, .file_rd,
    .file_we, .file_wdata, .acc, .carry_flag, .digit_carry_flag, .zero_flag, .nop_cycle, .qphase);
  mie_rf_model u_rf (.clk_sys, .file_addr, .file_rd, .file_we, .file_wdata, .file_rdata);
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic st();
    chk(acc, w_x);
    chk({5'h0, carry_flag, digit_carry_flag, zero_flag}, {5'h0, fl_x});
  endtask
  // Word goes out at the phase three falling edge, result read one cycle later
  // Word is swapped for a no-op once latched, so a late return never repeats it
  task automatic exec(input logic [13:0] w);
    for (int n = 0; n < 8 && qphase !== 2'h3; n++) @(negedge clk_sys);
    insn = w;
    nop_seen = 1'b0;
    repeat (4) begin
      @(negedge clk_sys);
      insn = '0;
      nop_seen = nop_seen | nop_cycle;
    end
  endtask
  function automatic logic [10:0] sub8(input logic [7:0] a, input logic [7:0] b);
    return {a >= b, a[3:0] >= b[3:0], a == b, a - b};
  endfunction
  task automatic t_xorl(input logic [7:0] k);
    logic [PC_W-1:0] p;
    p = pc;
    exec({GRP_LIT, OP_XORL, k});
    w_x = w_x ^ k;
    fl_x[0] = (w_x == 8'h00);
    st();
    chk(8'(pc - p), 8'h01);
    $display("test xorl %h done", k);
  endtask
  task automatic t_subl(input logic [7:0] k, input logic x);
    exec({GRP_LIT, OP_SUBL, x, k});
    {fl_x, w_x} = sub8(k, w_x);
    st();
    $display("test subl %h done", k);
  endtask
  task automatic t_byte(input logic [3:0] op, input logic d, input logic [6:0] f);
    logic [7:0] s, r;
    s = fm[f];
    exec({GRP_BYTE, op, d, f});
    if (op == OP_SUB_ACC_FROM_REG) {fl_x, r} = sub8(s, w_x);
    else if (op == OP_XOR_ACC_WITH_REG) begin
      r = s ^ w_x;
      fl_x[0] = (r == 8'h00);
    end else r = {s[3:0], s[7:4]};
    if (d) fm[f] = r;
    else w_x = r;
    st();
    chk({7'h0, file_we}, {7'h0, d});
    if (d) chk(file_wdata, r);
    // Store lands at the phase three rising edge
    @(negedge clk_sys);
    chk(u_rf.mem[f], fm[f]);
    $display("test byte %h d %b done", op, d);
  endtask
  task automatic t_skip(input logic [1:0] op, input logic tk);
    exec({GRP_BIT, op, 3'h0, 7'h05});
    exec({GRP_LIT, OP_XORL, 8'hff});
    if (!tk) w_x = w_x ^ 8'hff;
    fl_x[0] = (w_x == 8'h00);
    st();
    chk({7'h0, nop_seen}, {7'h0, tk});
    $display("test skip %b done", tk);
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      results();
    end
  end
  initial begin
    for (int i = 0; i < 128; i++) fm[i] = 8'(i) ^ 8'h3c;
    w_x = 8'h00;
    fl_x = 3'h0;
    repeat (8) @(negedge clk_sys);
    rstn = 1'b1;
    st();
    t_xorl(8'ha5);
    t_xorl(8'ha5);
    t_xorl(8'h3c);
    t_subl(8'h10, 1'b0);
    t_subl(8'hd4, 1'b1);
    t_byte(OP_SUB_ACC_FROM_REG, 1'b1, 7'h7f);
    t_xorl(8'h5a);
    t_byte(OP_SUB_ACC_FROM_REG, 1'b0, 7'h00);
    t_byte(OP_XOR_ACC_WITH_REG, 1'b1, 7'h10);
    t_byte(OP_XOR_ACC_WITH_REG, 1'b0, 7'h11);
    t_byte(OP_NIBBLE_SWAP_REG, 1'b0, 7'h7f);
    t_byte(OP_NIBBLE_SWAP_REG, 1'b1, 7'h20);
    t_skip(OP_BTFSS, 1'b1);
    t_skip(OP_BTFSC, 1'b0);
    results();
  end
endmodule // tb
